// ### core/crp_consts.svh
// Addresses, field positions, reset values and steps of the core registers
`ifndef CRP_CONSTS_SVH
`define CRP_CONSTS_SVH

`define CRP_ADDR_LOOKUP   8'h82
`define CRP_ADDR_PTR_LO   8'h83
`define CRP_ADDR_PTR_HI   8'h84
`define CRP_ADDR_STATUS   8'h86
`define CRP_ADDR_PC_LO    8'hCE
`define CRP_ADDR_PC_HI    8'hCF
`define CRP_ADDR_INDIRECT 8'hE7

`define CRP_PC_W          13
`define CRP_PC_HI_W       5
`define CRP_PC_RESET      13'h0000
`define CRP_PC_STEP       13'h0001
`define CRP_PC_SKIP       13'h0002

`define CRP_BIT_C         2
`define CRP_BIT_DC        1
`define CRP_BIT_Z         0
`define CRP_CAUSE_MSB     7
`define CRP_CAUSE_LSB     6

`define CRP_BYTE_ZERO     8'h00
`define CRP_BYTE_ONE      8'h01
`define CRP_BYTE_MAX      8'hFF
`define CRP_FLAG_RESET    1'h0
`define CRP_CAUSE_RESET   2'h1
`define CRP_BANK_ZERO     8'h00

`endif

// ### core/crp_pkg.sv
// Types of the core register and program counter block
package crp_pkg;

  typedef enum logic [4:0] {
    CRP_OP_ADVANCE    = 5'h00,
    CRP_OP_MOV_TO_ACC = 5'h01,
    CRP_OP_MOV_TO_MEM = 5'h02,
    CRP_OP_ADD        = 5'h03,
    CRP_OP_ADC        = 5'h04,
    CRP_OP_SUB        = 5'h05,
    CRP_OP_AND        = 5'h06,
    CRP_OP_OR         = 5'h07,
    CRP_OP_XOR        = 5'h08,
    CRP_OP_ROT_LEFT   = 5'h09,
    CRP_OP_ROT_RIGHT  = 5'h0A,
    CRP_OP_CMP_SKIP   = 5'h0B,
    CRP_OP_INC_S_ACC  = 5'h0C,
    CRP_OP_INC_S_MEM  = 5'h0D,
    CRP_OP_DEC_S_ACC  = 5'h0E,
    CRP_OP_DEC_S_MEM  = 5'h0F,
    CRP_OP_SKIP_CLR   = 5'h10,
    CRP_OP_SKIP_SET   = 5'h11,
    CRP_OP_JUMP       = 5'h12,
    CRP_OP_SAVE       = 5'h13,
    CRP_OP_RESTORE    = 5'h14,
    CRP_OP_ROM_READ   = 5'h15,
    CRP_OP_IRQ_ENTRY  = 5'h16
  } crp_op_t;

  typedef enum logic [1:0] {
    CRP_CAUSE_WATCHDOG = 2'h0,
    CRP_CAUSE_RESERVED = 2'h1,
    CRP_CAUSE_LOW_VOLT = 2'h2,
    CRP_CAUSE_PIN      = 2'h3
  } crp_cause_t;

  typedef struct packed {
    logic        valid;
    crp_op_t     op;
    logic        is_mem;
    logic        to_mem;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [2:0]  bit_sel;
    logic [12:0] target;
  } crp_cmd_t;

endpackage : crp_pkg

// ### core/crp_core.sv
// Accumulator, status flags, program counter, pointer pair and look-up register
//
// Contract
// RULE_01 - 8-bit accumulator; ALU results set flags
// RULE_02 - Accumulator has no data memory address
// RULE_03 - Interrupt entry saves neither accumulator nor flags
// RULE_04 - Save and restore copy accumulator and flags
// RULE_05 - Status bits 7:6 give reset cause
// RULE_06 - Carry flag in bit 2
// RULE_07 - Nibble carry flag in bit 1
// RULE_08 - Zero flag in bit 0
// RULE_09 - 13-bit counter, cleared at reset
// RULE_10 - Counter advances by one per instruction
// RULE_11 - Jump and call load whole counter
// RULE_12 - True skip condition advances counter by two
// RULE_13 - Bit test skips on tested value
// RULE_14 - Compare skips when accumulator equals operand
// RULE_15 - Increment skips on wrap to zero
// RULE_16 - Decrement skips on wrap to all ones
// RULE_17 - Add into low byte carries into high
// RULE_18 - Subtract from low byte leaves high byte
// RULE_19 - Move into low byte jumps within page
// RULE_20 - Two 8-bit pointer registers
// RULE_21 - Upper pointer picks bank, lower picks location
// RULE_22 - Table read splits word to look-up and accumulator
`timescale 1ns/1ps
`include "crp_consts.svh"

module crp_core (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire crp_pkg::crp_cmd_t i_cmd,
  input  wire logic [15:0]      i_rom_word,
  input  wire logic [1:0]       i_reset_cause,
  output logic [7:0]            o_accumulator,
  output logic [7:0]            o_status_flags,
  output logic [12:0]           o_program_counter,
  output logic [7:0]            o_pointer_high,
  output logic [7:0]            o_pointer_low,
  output logic [7:0]            o_lookup_high_byte,
  output logic                  o_mem_we,
  output logic [15:0]           o_mem_addr,
  output logic [7:0]            o_mem_wdata
);
  import crp_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  logic [7:0]  acc_reg, acc_save_reg, flags_save_reg;
  logic        c_reg, dc_reg, z_reg;
  logic [1:0]  cause_reg;
  logic        cause_pending_reg;
  logic [12:0] pc_reg;
  logic [7:0]  ptr_hi_reg, ptr_lo_reg, lookup_reg;
  logic        mem_we_reg;
  logic [15:0] mem_addr_reg;
  logic [7:0]  mem_wdata_reg;

  logic [7:0]  status_now, int_val, src, res;
  logic        int_hit, c_next, dc_next, upd_c, upd_dc, upd_z;
  logic [8:0]  wide;
  logic        wr_acc, wr_dst, skip, cin, act;

  assign act        = i_cmd.valid;
  assign status_now = {cause_reg, 3'h0, c_reg, dc_reg, z_reg};

  // ********************************************************************
  // Operand fetch
  // ********************************************************************
  // RULE_02 accumulator not decoded
  always_comb begin
    int_hit = 1'b1;
    int_val = `CRP_BYTE_ZERO;
    unique case (i_cmd.addr)
      `CRP_ADDR_LOOKUP: int_val = lookup_reg;
      `CRP_ADDR_PTR_LO: int_val = ptr_lo_reg;
      `CRP_ADDR_PTR_HI: int_val = ptr_hi_reg;
      `CRP_ADDR_STATUS: int_val = status_now;
      `CRP_ADDR_PC_LO:  int_val = pc_reg[7:0];
      `CRP_ADDR_PC_HI:  int_val = {3'h0, pc_reg[12:8]};
      default:          int_hit = 1'b0;
    endcase
    src = (i_cmd.is_mem && int_hit) ? int_val : i_cmd.data;
  end

  // ********************************************************************
  // ALU and skip decision
  // ********************************************************************
  always_comb begin
    res     = `CRP_BYTE_ZERO;
    wide    = 9'h000;
    c_next  = c_reg;
    dc_next = dc_reg;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    wr_acc  = 1'b0;
    wr_dst  = 1'b0;
    skip    = 1'b0;
    cin     = (i_cmd.op == CRP_OP_ADC) ? c_reg : 1'b0;
    unique case (i_cmd.op)
      CRP_OP_MOV_TO_ACC: begin
        res    = src;
        wr_acc = 1'b1;
      end
      CRP_OP_MOV_TO_MEM: begin
        res    = acc_reg;
        wr_dst = 1'b1;
      end
      // RULE_06 add carry out
      CRP_OP_ADD, CRP_OP_ADC: begin
        wide    = {1'b0, acc_reg} + {1'b0, src} + {8'h00, cin};
        res     = wide[7:0];
        c_next  = wide[8];
        // RULE_07 low nibble carry
        dc_next = ({1'b0, acc_reg[3:0]} + {1'b0, src[3:0]} + {4'h0, cin}) > 5'h0F;
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
        wr_acc  = ~i_cmd.to_mem;
        wr_dst  = i_cmd.to_mem;
      end
      // RULE_06 carry means no borrow
      CRP_OP_SUB: begin
        if (i_cmd.to_mem) begin
          wide    = {1'b0, src} - {1'b0, acc_reg};
          dc_next = src[3:0] >= acc_reg[3:0];
        end else begin
          wide    = {1'b0, acc_reg} - {1'b0, src};
          dc_next = acc_reg[3:0] >= src[3:0];
        end
        res    = wide[7:0];
        c_next = ~wide[8];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
        wr_acc = ~i_cmd.to_mem;
        wr_dst = i_cmd.to_mem;
      end
      CRP_OP_AND, CRP_OP_OR, CRP_OP_XOR: begin
        if (i_cmd.op == CRP_OP_AND) begin
          res = acc_reg & src;
        end else if (i_cmd.op == CRP_OP_OR) begin
          res = acc_reg | src;
        end else begin
          res = acc_reg ^ src;
        end
        upd_z  = 1'b1;
        wr_acc = ~i_cmd.to_mem;
        wr_dst = i_cmd.to_mem;
      end
      // RULE_06 carry takes shifted-out bit
      CRP_OP_ROT_LEFT, CRP_OP_ROT_RIGHT: begin
        if (i_cmd.op == CRP_OP_ROT_LEFT) begin
          res    = {src[6:0], c_reg};
          c_next = src[7];
        end else begin
          res    = {c_reg, src[7:1]};
          c_next = src[0];
        end
        upd_c  = 1'b1;
        wr_acc = ~i_cmd.to_mem;
        wr_dst = i_cmd.to_mem;
      end
      // RULE_14 equal operands skip
      CRP_OP_CMP_SKIP: begin
        res    = acc_reg - src;
        c_next = acc_reg >= src;
        upd_c  = 1'b1;
        upd_z  = 1'b1;
        skip   = acc_reg == src;
      end
      // RULE_15 wrap to zero skips
      CRP_OP_INC_S_ACC, CRP_OP_INC_S_MEM: begin
        res    = src + `CRP_BYTE_ONE;
        skip   = res == `CRP_BYTE_ZERO;
        wr_acc = i_cmd.op == CRP_OP_INC_S_ACC;
        wr_dst = i_cmd.op == CRP_OP_INC_S_MEM;
      end
      // RULE_16 wrap to all ones skips
      CRP_OP_DEC_S_ACC, CRP_OP_DEC_S_MEM: begin
        res    = src - `CRP_BYTE_ONE;
        skip   = res == `CRP_BYTE_MAX;
        wr_acc = i_cmd.op == CRP_OP_DEC_S_ACC;
        wr_dst = i_cmd.op == CRP_OP_DEC_S_MEM;
      end
      // RULE_13 tested bit value
      CRP_OP_SKIP_CLR: skip = ~src[i_cmd.bit_sel];
      CRP_OP_SKIP_SET: skip = src[i_cmd.bit_sel];
      default: res = `CRP_BYTE_ZERO;
    endcase
  end

  // ********************************************************************
  // Accumulator
  // ********************************************************************
  // RULE_01 accumulator updates
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      acc_reg <= `CRP_BYTE_ZERO;
    end else if (act) begin
      if (i_cmd.op == CRP_OP_RESTORE) begin
        acc_reg <= acc_save_reg;
      end else if (i_cmd.op == CRP_OP_ROM_READ) begin
        acc_reg <= i_rom_word[7:0];
      end else if (wr_acc) begin
        acc_reg <= res;
      end
    end
  end

  // ********************************************************************
  // Status flags
  // ********************************************************************
  // RULE_03 interrupt entry falls through untouched
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      c_reg  <= `CRP_FLAG_RESET;
      dc_reg <= `CRP_FLAG_RESET;
      z_reg  <= `CRP_FLAG_RESET;
    end else if (act) begin
      if (i_cmd.op == CRP_OP_RESTORE) begin
        c_reg  <= flags_save_reg[`CRP_BIT_C];
        dc_reg <= flags_save_reg[`CRP_BIT_DC];
        z_reg  <= flags_save_reg[`CRP_BIT_Z];
      end else begin
        // ALU result wins over a direct store
        if (upd_c) begin
          c_reg <= c_next;
        end else if (wr_dst && i_cmd.addr == `CRP_ADDR_STATUS) begin
          c_reg <= res[`CRP_BIT_C];
        end
        if (upd_dc) begin
          dc_reg <= dc_next;
        end else if (wr_dst && i_cmd.addr == `CRP_ADDR_STATUS) begin
          dc_reg <= res[`CRP_BIT_DC];
        end
        // RULE_08 zero flag
        if (upd_z) begin
          z_reg <= res == `CRP_BYTE_ZERO;
        end else if (wr_dst && i_cmd.addr == `CRP_ADDR_STATUS) begin
          z_reg <= res[`CRP_BIT_Z];
        end
      end
    end
  end

  // RULE_05 cause caught after release
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cause_reg         <= `CRP_CAUSE_RESET;
      cause_pending_reg <= 1'b1;
    end else if (cause_pending_reg) begin
      cause_reg         <= i_reset_cause;
      cause_pending_reg <= 1'b0;
    end else if (act && i_cmd.op == CRP_OP_RESTORE) begin
      cause_reg <= flags_save_reg[`CRP_CAUSE_MSB:`CRP_CAUSE_LSB];
    end else if (act && wr_dst && i_cmd.addr == `CRP_ADDR_STATUS) begin
      cause_reg <= res[`CRP_CAUSE_MSB:`CRP_CAUSE_LSB];
    end
  end

  // RULE_04 save buffers
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      acc_save_reg   <= `CRP_BYTE_ZERO;
      flags_save_reg <= `CRP_BYTE_ZERO;
    end else if (act && i_cmd.op == CRP_OP_SAVE) begin
      acc_save_reg   <= acc_reg;
      flags_save_reg <= status_now;
    end
  end

  // ********************************************************************
  // Pointers and look-up register
  // ********************************************************************
  // RULE_20 working and pointer use
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      ptr_hi_reg <= `CRP_BYTE_ZERO;
      ptr_lo_reg <= `CRP_BYTE_ZERO;
    end else if (act && wr_dst) begin
      if (i_cmd.addr == `CRP_ADDR_PTR_HI) begin
        ptr_hi_reg <= res;
      end
      if (i_cmd.addr == `CRP_ADDR_PTR_LO) begin
        ptr_lo_reg <= res;
      end
    end
  end

  // RULE_22 high byte to look-up
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      lookup_reg <= `CRP_BYTE_ZERO;
    end else if (act && i_cmd.op == CRP_OP_ROM_READ) begin
      lookup_reg <= i_rom_word[15:8];
    end else if (act && wr_dst && i_cmd.addr == `CRP_ADDR_LOOKUP) begin
      lookup_reg <= res;
    end
  end

  // ********************************************************************
  // External data memory write
  // ********************************************************************
  // Stores to non-core addresses leave as a one-cycle strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= `CRP_BYTE_ZERO;
    end else begin
      mem_we_reg <= act && wr_dst && !int_hit;
      if (act && wr_dst && !int_hit) begin
        mem_wdata_reg <= res;
        // RULE_21 bank from upper pointer
        if (i_cmd.addr == `CRP_ADDR_INDIRECT) begin
          mem_addr_reg <= {ptr_hi_reg, ptr_lo_reg};
        end else begin
          mem_addr_reg <= {`CRP_BANK_ZERO, i_cmd.addr};
        end
      end
    end
  end

  // ********************************************************************
  // Program counter
  // ********************************************************************
  // RULE_09 cleared at reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pc_reg <= `CRP_PC_RESET;
    end else if (act) begin
      if (i_cmd.op == CRP_OP_JUMP || i_cmd.op == CRP_OP_IRQ_ENTRY) begin
        // RULE_11 whole counter loaded
        pc_reg <= i_cmd.target;
      end else if (wr_dst && i_cmd.addr == `CRP_ADDR_PC_LO) begin
        // RULE_17 carry reaches high byte
        // RULE_18 borrow never reaches it
        // RULE_19 other stores stay in page
        pc_reg <= {pc_reg[12:8] + {4'h0, upd_dc && c_next && i_cmd.op != CRP_OP_SUB},
                   res};
      end else if (wr_dst && i_cmd.addr == `CRP_ADDR_PC_HI) begin
        pc_reg <= {res[`CRP_PC_HI_W-1:0], pc_reg[7:0] + `CRP_BYTE_ONE};
      end else if (skip) begin
        // RULE_12 skip over next word
        pc_reg <= pc_reg + `CRP_PC_SKIP;
      end else begin
        // RULE_10 plain advance
        pc_reg <= pc_reg + `CRP_PC_STEP;
      end
    end
  end

  assign o_accumulator      = acc_reg;
  assign o_status_flags     = status_now;
  assign o_program_counter  = pc_reg;
  assign o_pointer_high     = ptr_hi_reg;
  assign o_pointer_low      = ptr_lo_reg;
  assign o_lookup_high_byte = lookup_reg;
  assign o_mem_we           = mem_we_reg;
  assign o_mem_addr         = mem_addr_reg;
  assign o_mem_wdata        = mem_wdata_reg;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence save_seen;
    act && i_cmd.op == CRP_OP_SAVE;
  endsequence
  sequence restore_seen;
    act && i_cmd.op == CRP_OP_RESTORE;
  endsequence

  pc_reset_a: assert property (@(posedge i_ref_clk) disable iff (1'b0) // RULE_09
    !i_nrst |=> pc_reg == `CRP_PC_RESET) else $error("counter not cleared by reset");
  pc_advance_a: assert property ( // RULE_10
    act && i_cmd.op == CRP_OP_ADVANCE |=> pc_reg == $past(pc_reg) + `CRP_PC_STEP)
    else $error("counter did not advance by one");
  skip_step_a: assert property ( // RULE_12
    act && skip && !wr_dst |=> pc_reg == $past(pc_reg) + `CRP_PC_SKIP)
    else $error("skip did not advance by two");
  jump_load_a: assert property ( // RULE_11
    act && i_cmd.op == CRP_OP_JUMP |=> pc_reg == $past(i_cmd.target))
    else $error("jump target not loaded");
  pcl_carry_a: assert property ( // RULE_17
    act && wr_dst && i_cmd.addr == `CRP_ADDR_PC_LO && i_cmd.op == CRP_OP_ADD && c_next
    |=> pc_reg[12:8] == $past(pc_reg[12:8]) + 5'h01) else $error("low byte carry lost");
  pcl_borrow_a: assert property ( // RULE_18
    act && wr_dst && i_cmd.addr == `CRP_ADDR_PC_LO && i_cmd.op == CRP_OP_SUB
    |=> $stable(pc_reg[12:8])) else $error("borrow changed high byte");
  irq_keep_a: assert property ( // RULE_03
    act && i_cmd.op == CRP_OP_IRQ_ENTRY |=> $stable(acc_reg) && $stable(status_now))
    else $error("interrupt entry touched accumulator or flags");
  save_restore_a: assert property ( // RULE_04
    save_seen ##1 (!(act && i_cmd.op == CRP_OP_SAVE)) [*3] ##0 restore_seen
    |=> acc_reg == $past(acc_save_reg, 1) && status_now[2:0] == $past(flags_save_reg[2:0]))
    else $error("restore lost accumulator or flags");
  rom_split_a: assert property ( // RULE_22
    act && i_cmd.op == CRP_OP_ROM_READ
    |=> acc_reg == $past(i_rom_word[7:0]) && lookup_reg == $past(i_rom_word[15:8]))
    else $error("table word not split");
  zero_flag_a: assert property ( // RULE_08
    act && i_cmd.op == CRP_OP_AND && !i_cmd.to_mem |=> z_reg == (acc_reg == 8'h00))
    else $error("zero flag wrong after logic result");
  ind_addr_a: assert property ( // RULE_21
    act && wr_dst && i_cmd.addr == `CRP_ADDR_INDIRECT
    |=> o_mem_we && o_mem_addr == {$past(ptr_hi_reg), $past(ptr_lo_reg)})
    else $error("indirect store address wrong");

endmodule : crp_core

// ### bench/tb_crp_core.sv
// Self-checking bench for the core register and program counter block
`timescale 1ns/1ps
`include "crp_consts.svh"

module tb_crp_core;
  import crp_pkg::*;

  // ****************************************************************
  // Signals and reference state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  st;
    logic [12:0] pc;
    logic [7:0]  y;
    logic [7:0]  z;
    logic [7:0]  r;
    logic        we;
    logic [15:0] ma;
    logic [7:0]  wd;
  } crp_tb_exp_t;

  logic        i_ref_clk;
  logic        i_nrst;
  crp_cmd_t    i_cmd;
  logic [15:0] i_rom_word;
  logic [1:0]  i_reset_cause;
  logic [7:0]  o_accumulator;
  logic [7:0]  o_status_flags;
  logic [12:0] o_program_counter;
  logic [7:0]  o_pointer_high;
  logic [7:0]  o_pointer_low;
  logic [7:0]  o_lookup_high_byte;
  logic        o_mem_we;
  logic [15:0] o_mem_addr;
  logic [7:0]  o_mem_wdata;
  crp_tb_exp_t m;
  crp_tb_exp_t exp_q[$];
  logic [7:0]  sv_acc;
  logic [7:0]  sv_st;
  int          n_mismatch;
  int          comparisons;

  crp_core u_dut (
    .i_ref_clk          (i_ref_clk),
    .i_nrst             (i_nrst),
    .i_cmd              (i_cmd),
    .i_rom_word         (i_rom_word),
    .i_reset_cause      (i_reset_cause),
    .o_accumulator      (o_accumulator),
    .o_status_flags     (o_status_flags),
    .o_program_counter  (o_program_counter),
    .o_pointer_high     (o_pointer_high),
    .o_pointer_low      (o_pointer_low),
    .o_lookup_high_byte (o_lookup_high_byte),
    .o_mem_we           (o_mem_we),
    .o_mem_addr         (o_mem_addr),
    .o_mem_wdata        (o_mem_wdata)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Outputs settle one edge after the command, so compare just past it
  initial begin
    crp_tb_exp_t e;
    forever begin
      @(posedge i_ref_clk);
      #1;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk("accumulator", 16'(e.acc), 16'(o_accumulator));
        chk("status_flags", 16'(e.st), 16'(o_status_flags));
        chk("program_counter", 16'(e.pc), 16'(o_program_counter));
        chk("pointer_high", 16'(e.y), 16'(o_pointer_high));
        chk("pointer_low", 16'(e.z), 16'(o_pointer_low));
        chk("lookup_high_byte", 16'(e.r), 16'(o_lookup_high_byte));
        chk("mem_we", 16'(e.we), 16'(o_mem_we));
        chk("mem_addr", e.ma, o_mem_addr);
        chk("mem_wdata", 16'(e.wd), 16'(o_mem_wdata));
      end
    end
  end

  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  // ****************************************************************
  // Drivers with reference model
  // ****************************************************************
  task automatic rst_seq(input logic [1:0] cause);
    repeat (5) begin
      @(negedge i_ref_clk);
      i_nrst = 1'b0;
      i_cmd = '0;
      i_reset_cause = cause;
      m = '0;
      m.st = 8'h40;
      exp_q.push_back(m);
    end
    @(negedge i_ref_clk);
    i_nrst = 1'b1;
    m.st[7:6] = cause;
    exp_q.push_back(m);
  endtask : rst_seq

  task automatic step(input crp_cmd_t c);
    logic [8:0]  s;
    logic [7:0]  a, b, x, y, res;
    logic [2:0]  fl, fm;
    logic        wr, skip, cy, up;
    logic [12:0] npc;
    @(negedge i_ref_clk);
    i_cmd = c;
    i_rom_word = 16'($urandom);
    m.we = 1'b0;
    if (c.valid) begin
      a = m.acc;
      b = (c.is_mem && c.addr == `CRP_ADDR_PC_LO) ? m.pc[7:0] : c.data;
      x = c.to_mem ? b : a;
      y = c.to_mem ? a : b;
      {res, wr, skip, fl, fm, cy, up, s} = '0;
      npc = m.pc + `CRP_PC_STEP;
      case (c.op)
        CRP_OP_MOV_TO_ACC: m.acc = b;
        CRP_OP_MOV_TO_MEM: begin
          res = a;
          wr = 1'b1;
        end
        CRP_OP_ADD, CRP_OP_ADC, CRP_OP_SUB: begin
          cy = (c.op == CRP_OP_ADC) & m.st[`CRP_BIT_C];
          if (c.op == CRP_OP_SUB) begin
            s = {1'b0, x} - {1'b0, y};
            fl[2:1] = {~s[8], x[3:0] >= y[3:0]};
          end else begin
            s = {1'b0, x} + {1'b0, y} + 9'(cy);
            fl[2:1] = {s[8], (5'(x[3:0]) + 5'(y[3:0]) + 5'(cy)) > 5'h0F};
            up = s[8];
          end
          res = s[7:0];
          fm = 3'h7;
        end
        CRP_OP_AND, CRP_OP_OR, CRP_OP_XOR: begin
          res = (c.op == CRP_OP_AND) ? (a & b) : (c.op == CRP_OP_OR) ? (a | b) : (a ^ b);
          fm = 3'h1;
        end
        CRP_OP_ROT_LEFT, CRP_OP_ROT_RIGHT: begin
          {fl[2], res} = (c.op == CRP_OP_ROT_LEFT) ? {b, m.st[2]} : {b[0], m.st[2], b[7:1]};
          fm = 3'h4;
        end
        CRP_OP_CMP_SKIP: begin
          fl = {a >= b, 1'b0, a == b};
          fm = 3'h5;
          skip = (a == b);
        end
        CRP_OP_INC_S_ACC, CRP_OP_INC_S_MEM: begin
          res = b + 8'h01;
          skip = (res == 8'h00);
        end
        CRP_OP_DEC_S_ACC, CRP_OP_DEC_S_MEM: begin
          res = b - 8'h01;
          skip = (res == 8'hFF);
        end
        CRP_OP_SKIP_CLR: skip = ~b[c.bit_sel];
        CRP_OP_SKIP_SET: skip = b[c.bit_sel];
        CRP_OP_JUMP, CRP_OP_IRQ_ENTRY: npc = c.target;
        CRP_OP_SAVE: begin
          sv_acc = m.acc;
          sv_st = m.st;
        end
        CRP_OP_RESTORE: begin
          m.acc = sv_acc;
          m.st = sv_st;
        end
        CRP_OP_ROM_READ: {m.r, m.acc} = i_rom_word;
        default: ;
      endcase
      if (c.op inside {[CRP_OP_ADD:CRP_OP_ROT_RIGHT]}) begin
        fl[0] = (res == 8'h00);
        if (c.to_mem)
          wr = 1'b1;
        else
          m.acc = res;
      end
      if (c.op inside {CRP_OP_INC_S_ACC, CRP_OP_DEC_S_ACC})
        m.acc = res;
      if (c.op inside {CRP_OP_INC_S_MEM, CRP_OP_DEC_S_MEM})
        wr = 1'b1;
      if (skip)
        npc = m.pc + `CRP_PC_SKIP;
      if (wr) begin
        case (c.addr)
          `CRP_ADDR_LOOKUP: m.r = res;
          `CRP_ADDR_PTR_LO: m.z = res;
          `CRP_ADDR_PTR_HI: m.y = res;
          `CRP_ADDR_STATUS: m.st = res & 8'hC7;
          `CRP_ADDR_PC_LO: npc = {m.pc[12:8] + 5'(up), res};
          `CRP_ADDR_PC_HI: npc = {res[4:0], m.pc[7:0] + 8'h01};
          default: begin
            m.we = 1'b1;
            m.ma = (c.addr == `CRP_ADDR_INDIRECT) ? {m.y, m.z} : {8'h00, c.addr};
            m.wd = res;
          end
        endcase
      end
      // Same instruction's flags win over a status store
      m.st[2:0] = (m.st[2:0] & ~fm) | (fl & fm);
      m.pc = npc;
    end
    exp_q.push_back(m);
  endtask : step

  function automatic crp_cmd_t mk(input crp_op_t op, input logic tm, input logic im,
                                  input logic [7:0] ad, input logic [7:0] d);
    crp_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.op = op;
    c.to_mem = tm;
    c.is_mem = im;
    c.addr = ad;
    c.data = d;
    return c;
  endfunction : mk

  task automatic go(input crp_op_t op, input logic tm, input logic im,
                    input logic [7:0] ad, input logic [7:0] d);
    step(mk(op, tm, im, ad, d));
  endtask : go

  task automatic jmp(input crp_op_t op, input logic [12:0] t);
    crp_cmd_t c;
    c = mk(op, 1'b0, 1'b0, 8'h00, 8'h00);
    c.target = t;
    step(c);
  endtask : jmp

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    crp_cmd_t c;
    static logic [7:0] edge_v[3] = '{8'hFF, 8'h00, 8'h7F};
    i_nrst = 1'b0;
    i_cmd = '0;
    i_rom_word = 16'h0000;
    i_reset_cause = 2'h3;
    void'($urandom(32'h87a6e03d));
    for (int k = 0; k < 4; k++) begin
      rst_seq(2'(k));
      repeat (3) go(CRP_OP_ADVANCE, 1'b0, 1'b0, 8'h00, 8'h00);
    end
    step('0);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h12);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_PTR_HI, 8'h00);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h34);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_PTR_LO, 8'h00);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_INDIRECT, 8'h00);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_LOOKUP, 8'h00);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, 8'h10, 8'h00);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'hF0);
    go(CRP_OP_ADD, 1'b0, 1'b0, 8'h00, 8'h10);
    for (int k = 0; k < 60; k++) begin
      go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'($urandom));
      go(crp_op_t'(5'($urandom_range(10, 3))), k[0], k[0], 8'h10, 8'($urandom));
    end
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h12);
    for (int k = 0; k < 3; k++)
      go(CRP_OP_CMP_SKIP, 1'b0, 1'b0, 8'h00, 8'(8'h11 + k));
    for (int j = 0; j < 4; j++)
      for (int k = 0; k < 4; k++)
        go(crp_op_t'(5'(12 + j)), 1'b0, 1'b1, 8'h10,
           (k < 3) ? edge_v[k] : 8'($urandom));
    for (int k = 0; k < 16; k++) begin
      c = mk(crp_op_t'(5'(16 + k[0])), 1'b0, 1'b1, 8'h10, 8'($urandom));
      c.bit_sel = 3'($urandom);
      step(c);
    end
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'hF0);
    for (int k = 0; k < 2; k++) begin
      jmp(CRP_OP_JUMP, 13'h0323);
      go(k ? CRP_OP_ADC : CRP_OP_ADD, 1'b1, 1'b1, `CRP_ADDR_PC_LO, 8'h00);
    end
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h30);
    jmp(CRP_OP_JUMP, 13'h0323);
    go(CRP_OP_SUB, 1'b1, 1'b1, `CRP_ADDR_PC_LO, 8'h00);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h28);
    jmp(CRP_OP_JUMP, 13'h0323);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_PC_LO, 8'h00);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_PC_HI, 8'h00);
    jmp(CRP_OP_JUMP, 13'h1FFF);
    go(CRP_OP_ADVANCE, 1'b0, 1'b0, 8'h00, 8'h00);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'h5A);
    go(CRP_OP_ADD, 1'b0, 1'b0, 8'h00, 8'hA6);
    go(CRP_OP_SAVE, 1'b0, 1'b0, 8'h00, 8'h00);
    go(CRP_OP_ADD, 1'b0, 1'b0, 8'h00, 8'h01);
    jmp(CRP_OP_IRQ_ENTRY, 13'h0008);
    go(CRP_OP_RESTORE, 1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) go(CRP_OP_ROM_READ, 1'b0, 1'b0, 8'h00, 8'h00);
    go(CRP_OP_MOV_TO_ACC, 1'b0, 1'b0, 8'h00, 8'hFF);
    go(CRP_OP_MOV_TO_MEM, 1'b1, 1'b1, `CRP_ADDR_STATUS, 8'h00);
    go(CRP_OP_ADD, 1'b1, 1'b0, `CRP_ADDR_STATUS, 8'h01);
    for (int k = 0; k < 8 && exp_q.size() > 0; k++)
      @(posedge i_ref_clk);
    #2;
    if (exp_q.size() > 0)
      n_mismatch++;
    give_verdict();
  end

endmodule : tb_crp_core
